// ### inc/cpsreg_pkg.sv
package cpsreg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int GPR_NUM = 16;
    localparam int GPR_IDX_W = 4;
    localparam int ILM_W = 5;

    // register byte offsets (one aligned word each)
    localparam logic [7:0] OFS_GPR_BASE = 8'h00;
    localparam logic [7:0] OFS_GPR_LAST = 8'h3c;
    localparam logic [7:0] OFS_PS = 8'h40;
    localparam logic [7:0] OFS_MDH = 8'h44;
    localparam logic [7:0] OFS_MDL = 8'h48;
    localparam logic [7:0] OFS_SSP = 8'h4c;
    localparam logic [7:0] OFS_USP = 8'h50;
    localparam logic [7:0] OFS_SAVED_PS = 8'h54;

    // status word layout
    localparam int PS_C_BIT = 0;
    localparam int PS_I_BIT = 4;
    localparam int PS_S_BIT = 5;
    localparam int PS_T_BIT = 8;
    localparam int PS_D0_BIT = 9;
    localparam int PS_D1_BIT = 10;
    localparam int PS_ILM_LSB = 16;
    localparam int PS_ILM_MSB = 20;
    localparam int CCR_MSB = 7;
    localparam logic [31:0] PS_DEF_MASK = 32'h001f073f;
    localparam logic [31:0] PS_NZVC_MASK = 32'h0000000f;
    localparam logic [4:0] ILM_RESET = 5'h0f;
    localparam logic [31:0] PS_RESET = 32'h000f0000;
    localparam logic [31:0] SSP_RESET = 32'h00000000;

    // timing in cpu clock cycles
    localparam logic [2:0] MUL_WIDE_CYC = 3'h5;
    localparam logic [2:0] MUL_HALF_CYC = 3'h3;
    localparam logic [2:0] ENTRY_CYC = 3'h6;

    typedef enum logic [1:0] {
        PS_OP_NONE = 2'b00,
        PS_OP_OR_CCR = 2'b01,
        PS_OP_SET_ILM = 2'b10,
        PS_OP_MOVE = 2'b11
    } cpsreg_ps_op_t;

    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_BUSY = 1'b1
    } cpsreg_seq_t;

    typedef struct packed {
        logic gpr_we;
        logic [3:0] gpr_idx;
        logic [31:0] gpr_wdata;
        logic dstep_we;
        logic [1:0] dstep_val;
        cpsreg_ps_op_t ps_op;
        logic [31:0] ps_val;
        logic exc_req;
        logic [4:0] exc_level;
        logic reti;
        logic mul_start;
        logic mul_wide;
        logic [31:0] mul_a;
        logic [31:0] mul_b;
    } cpsreg_pipe_req_t;
endpackage

// ### design/cpsreg_top.sv
`timescale 1ns/10ps
module cpsreg_top #(
    parameter logic [2:0] MUL_WIDE_CYC = cpsreg_pkg::MUL_WIDE_CYC,
    parameter logic [2:0] MUL_HALF_CYC = cpsreg_pkg::MUL_HALF_CYC,
    parameter logic [2:0] ENTRY_CYC = cpsreg_pkg::ENTRY_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire cpsreg_pkg::cpsreg_pipe_req_t pipe_req_in,
    output logic [31:0] ps_out,
    output logic [3:0] nzvc_out,
    output logic [31:0] sp_out,
    output logic entry_busy_out,
    output logic entry_done_out,
    output logic mul_busy_out,
    output logic mul_done_out
);
    function automatic logic is_gpr(input logic [7:0] a);
        return (a <= cpsreg_pkg::OFS_GPR_LAST) && (a[1:0] == 2'h0);
    endfunction

    // architectural state without reset
    logic [31:0] gpr_r [0:cpsreg_pkg::GPR_NUM-2];
    logic [31:0] usp_r, mdh_r, mdl_r;
    logic [3:0] nzvc_r, saved_nzvc_r;
    // state with reset
    logic [31:0] ps_r, ssp_r, sp_r, saved_ps_r, rdata_r;
    cpsreg_pkg::cpsreg_seq_t ent_state_r, mul_state_r;
    logic [2:0] ent_cnt_r, mul_cnt_r;
    logic [4:0] ent_level_r;
    logic ent_done_r, mul_wide_r, mul_done_r;
    logic [31:0] mul_a_r, mul_b_r;
    // next values
    logic [31:0] ps_nxt, ssp_nxt, sp_nxt, saved_ps_nxt, rdata_nxt;
    logic [31:0] usp_nxt, mdh_nxt, mdl_nxt, mul_a_nxt, mul_b_nxt;
    cpsreg_pkg::cpsreg_seq_t ent_state_nxt, mul_state_nxt;
    logic [2:0] ent_cnt_nxt, mul_cnt_nxt;
    logic [4:0] ent_level_nxt;
    logic ent_done_nxt, mul_wide_nxt, mul_done_nxt;
    logic [3:0] nzvc_nxt, saved_nzvc_nxt;
    logic [31:0] ps_cur, ps_early, ps_work, cur_sp, prod_half;
    logic ent_accept, ent_finish, reti_take, mul_finish, bus_gpr_we, pipe_gpr_we;
    logic [63:0] prod_wide;

    assign ps_cur = ps_r | {28'h0, nzvc_r};
    assign cur_sp = ps_r[cpsreg_pkg::PS_S_BIT] ? usp_r : ssp_r;
    // registers 0..14 live in the array; index 15 is the selected stack pointer
    assign bus_gpr_we = reg_wr_in && is_gpr(reg_addr_in) && (reg_addr_in[5:2] != 4'hf);
    assign pipe_gpr_we = pipe_req_in.gpr_we && (pipe_req_in.gpr_idx != 4'hf);
    assign ent_finish = (ent_state_r == cpsreg_pkg::SEQ_BUSY) && (ent_cnt_r == ENTRY_CYC);
    assign reti_take = pipe_req_in.reti && (ent_state_r == cpsreg_pkg::SEQ_IDLE);
    // lower mask value means higher priority; a handler may be interrupted
    // again by anything strictly above its own level
    assign ent_accept = (ent_state_r == cpsreg_pkg::SEQ_IDLE) && pipe_req_in.exc_req
        && ps_r[cpsreg_pkg::PS_I_BIT]
        && (pipe_req_in.exc_level < ps_r[cpsreg_pkg::PS_ILM_MSB:cpsreg_pkg::PS_ILM_LSB]);
    assign mul_finish = (mul_state_r == cpsreg_pkg::SEQ_BUSY)
        && (mul_cnt_r == (mul_wide_r ? MUL_WIDE_CYC : MUL_HALF_CYC));
    // operands sign-extended to the product width, so the whole result is the signed product
    assign prod_wide = {{32{mul_a_r[31]}}, mul_a_r} * {{32{mul_b_r[31]}}, mul_b_r};
    assign prod_half = {{16{mul_a_r[15]}}, mul_a_r[15:0]} * {{16{mul_b_r[15]}}, mul_b_r[15:0]};

    // status word, stack pointers and register read path
    always_comb begin
        ps_early = ps_cur;
        if (reg_wr_in && (reg_addr_in == cpsreg_pkg::OFS_PS)) ps_early = reg_wdata_in;
        // instruction effects land now, ahead of any exception taken this cycle,
        // so the saved copy already holds them and re-execution rewrites the same bits
        case (pipe_req_in.ps_op)
            cpsreg_pkg::PS_OP_OR_CCR: begin
                ps_early[cpsreg_pkg::CCR_MSB:0] = ps_early[cpsreg_pkg::CCR_MSB:0]
                    | pipe_req_in.ps_val[cpsreg_pkg::CCR_MSB:0];
            end
            cpsreg_pkg::PS_OP_SET_ILM: begin
                ps_early[cpsreg_pkg::PS_ILM_MSB:cpsreg_pkg::PS_ILM_LSB] =
                    pipe_req_in.ps_val[cpsreg_pkg::ILM_W-1:0];
            end
            cpsreg_pkg::PS_OP_MOVE: begin
                ps_early = pipe_req_in.ps_val;
            end
            default: ps_early = ps_early;
        endcase
        if (pipe_req_in.dstep_we) begin
            ps_early[cpsreg_pkg::PS_D1_BIT:cpsreg_pkg::PS_D0_BIT] = pipe_req_in.dstep_val;
        end
        ps_work = ps_early;
        saved_ps_nxt = saved_ps_r;
        saved_nzvc_nxt = saved_nzvc_r;
        if (ent_accept) begin
            saved_ps_nxt = ps_early & cpsreg_pkg::PS_DEF_MASK & ~cpsreg_pkg::PS_NZVC_MASK;
            saved_nzvc_nxt = ps_early[3:0];
        end
        if (reti_take) begin
            ps_work = saved_ps_r | {28'h0, saved_nzvc_r};
        end
        if (ent_finish) begin
            ps_work[cpsreg_pkg::PS_ILM_MSB:cpsreg_pkg::PS_ILM_LSB] = ent_level_r;
            ps_work[cpsreg_pkg::PS_S_BIT] = 1'b0;
        end
        ps_nxt = ps_work & cpsreg_pkg::PS_DEF_MASK & ~cpsreg_pkg::PS_NZVC_MASK;
        nzvc_nxt = ps_work[3:0];
        ssp_nxt = ssp_r;
        usp_nxt = usp_r;
        if (reg_wr_in && (reg_addr_in == cpsreg_pkg::OFS_SSP)) ssp_nxt = reg_wdata_in;
        if (reg_wr_in && (reg_addr_in == cpsreg_pkg::OFS_USP)) usp_nxt = reg_wdata_in;
        if (reg_wr_in && is_gpr(reg_addr_in) && (reg_addr_in[5:2] == 4'hf)) begin
            if (ps_r[cpsreg_pkg::PS_S_BIT]) begin
                usp_nxt = reg_wdata_in;
            end else begin
                ssp_nxt = reg_wdata_in;
            end
        end
        // pipeline write lands in the same cycle as a bus access and wins a tie
        if (pipe_req_in.gpr_we && (pipe_req_in.gpr_idx == 4'hf)) begin
            if (ps_r[cpsreg_pkg::PS_S_BIT]) begin
                usp_nxt = pipe_req_in.gpr_wdata;
            end else begin
                ssp_nxt = pipe_req_in.gpr_wdata;
            end
        end
        sp_nxt = ps_nxt[cpsreg_pkg::PS_S_BIT] ? usp_nxt : ssp_nxt;
        mdh_nxt = mdh_r;
        mdl_nxt = mdl_r;
        if (reg_wr_in && (reg_addr_in == cpsreg_pkg::OFS_MDH)) mdh_nxt = reg_wdata_in;
        if (reg_wr_in && (reg_addr_in == cpsreg_pkg::OFS_MDL)) mdl_nxt = reg_wdata_in;
        if (mul_finish) begin
            if (mul_wide_r) begin
                mdh_nxt = prod_wide[63:32];
                mdl_nxt = prod_wide[31:0];
            end else begin
                mdl_nxt = prod_half;
            end
        end
        rdata_nxt = 32'h0;
        if (reg_rd_in) begin
            if (is_gpr(reg_addr_in)) begin
                rdata_nxt = (reg_addr_in[5:2] == 4'hf) ? cur_sp : gpr_r[reg_addr_in[5:2]];
            end else begin
                case (reg_addr_in)
                    cpsreg_pkg::OFS_PS: rdata_nxt = ps_cur;
                    cpsreg_pkg::OFS_MDH: rdata_nxt = mdh_r;
                    cpsreg_pkg::OFS_MDL: rdata_nxt = mdl_r;
                    cpsreg_pkg::OFS_SSP: rdata_nxt = ssp_r;
                    cpsreg_pkg::OFS_USP: rdata_nxt = usp_r;
                    cpsreg_pkg::OFS_SAVED_PS: rdata_nxt = saved_ps_r | {28'h0, saved_nzvc_r};
                    default: rdata_nxt = 32'h0;
                endcase
            end
        end
    end
    // interrupt entry sequencer and multiplier sequencer
    always_comb begin
        ent_state_nxt = ent_state_r;
        ent_cnt_nxt = ent_cnt_r;
        ent_level_nxt = ent_level_r;
        ent_done_nxt = 1'b0;
        case (ent_state_r)
            cpsreg_pkg::SEQ_IDLE: begin
                if (ent_accept) begin
                    ent_state_nxt = cpsreg_pkg::SEQ_BUSY;
                    ent_cnt_nxt = 3'h1;
                    ent_level_nxt = pipe_req_in.exc_level;
                end
            end
            cpsreg_pkg::SEQ_BUSY: begin
                if (ent_finish) begin
                    ent_state_nxt = cpsreg_pkg::SEQ_IDLE;
                    ent_done_nxt = 1'b1;
                end else begin
                    ent_cnt_nxt = ent_cnt_r + 3'h1;
                end
            end
            default: ent_state_nxt = cpsreg_pkg::SEQ_IDLE;
        endcase

        mul_state_nxt = mul_state_r;
        mul_cnt_nxt = mul_cnt_r;
        mul_wide_nxt = mul_wide_r;
        mul_a_nxt = mul_a_r;
        mul_b_nxt = mul_b_r;
        mul_done_nxt = 1'b0;
        case (mul_state_r)
            cpsreg_pkg::SEQ_IDLE: begin
                if (pipe_req_in.mul_start) begin
                    mul_state_nxt = cpsreg_pkg::SEQ_BUSY;
                    mul_cnt_nxt = 3'h1;
                    mul_wide_nxt = pipe_req_in.mul_wide;
                    mul_a_nxt = pipe_req_in.mul_a;
                    mul_b_nxt = pipe_req_in.mul_b;
                end
            end
            cpsreg_pkg::SEQ_BUSY: begin
                if (mul_finish) begin
                    mul_state_nxt = cpsreg_pkg::SEQ_IDLE;
                    mul_done_nxt = 1'b1;
                end else begin
                    mul_cnt_nxt = mul_cnt_r + 3'h1;
                end
            end
            default: mul_state_nxt = cpsreg_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ps_r <= cpsreg_pkg::PS_RESET;
            ssp_r <= cpsreg_pkg::SSP_RESET;
            sp_r <= cpsreg_pkg::SSP_RESET;
            saved_ps_r <= cpsreg_pkg::PS_RESET;
            rdata_r <= 32'h0;
            ent_state_r <= cpsreg_pkg::SEQ_IDLE;
            ent_cnt_r <= 3'h0;
            ent_level_r <= 5'h0;
            ent_done_r <= 1'b0;
            mul_state_r <= cpsreg_pkg::SEQ_IDLE;
            mul_cnt_r <= 3'h0;
            mul_wide_r <= 1'b0;
            mul_a_r <= 32'h0;
            mul_b_r <= 32'h0;
            mul_done_r <= 1'b0;
        end else begin
            ps_r <= ps_nxt;
            ssp_r <= ssp_nxt;
            sp_r <= sp_nxt;
            saved_ps_r <= saved_ps_nxt;
            rdata_r <= rdata_nxt;
            ent_state_r <= ent_state_nxt;
            ent_cnt_r <= ent_cnt_nxt;
            ent_level_r <= ent_level_nxt;
            ent_done_r <= ent_done_nxt;
            mul_state_r <= mul_state_nxt;
            mul_cnt_r <= mul_cnt_nxt;
            mul_wide_r <= mul_wide_nxt;
            mul_a_r <= mul_a_nxt;
            mul_b_r <= mul_b_nxt;
            mul_done_r <= mul_done_nxt;
        end
    end

    // no reset here: these hold whatever the last write left, as the core allows
    always_ff @(posedge sys_clk_in) begin
        if (bus_gpr_we) begin
            gpr_r[reg_addr_in[5:2]] <= reg_wdata_in;
        end
        if (pipe_gpr_we) begin
            gpr_r[pipe_req_in.gpr_idx] <= pipe_req_in.gpr_wdata;
        end
        usp_r <= usp_nxt;
        mdh_r <= mdh_nxt;
        mdl_r <= mdl_nxt;
        nzvc_r <= nzvc_nxt;
        saved_nzvc_r <= saved_nzvc_nxt;
    end

    assign reg_rdata_out = rdata_r;
    assign ps_out = ps_r;
    assign nzvc_out = nzvc_r;
    assign sp_out = sp_r;
    assign entry_busy_out = ent_state_r;
    assign entry_done_out = ent_done_r;
    assign mul_busy_out = mul_state_r;
    assign mul_done_out = mul_done_r;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_entry_run;
        entry_busy_out [*6] ##1 entry_done_out;
    endsequence
    sequence s_mul_wide_run;
        mul_busy_out [*5] ##1 mul_done_out;
    endsequence

    property p_ps_reserved_zero;
        (ps_out & ~cpsreg_pkg::PS_DEF_MASK) == 32'h0;
    endproperty
    a_ps_reserved_zero: assert property (p_ps_reserved_zero) else $error("reserved ps bit set");
    property p_reset_values;
        $rose(rst_n_in) |-> (ps_out[20:16] == 5'h0f) && !ps_out[5] && !ps_out[4] && (sp_out == 32'h0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset state");
    property p_entry_six;
        ent_accept |=> s_entry_run;
    endproperty
    a_entry_six: assert property (p_entry_six) else $error("entry not six cycles");
    property p_mul_wide;
        (pipe_req_in.mul_start && pipe_req_in.mul_wide && !mul_busy_out) |=> s_mul_wide_run;
    endproperty
    a_mul_wide: assert property (p_mul_wide) else $error("wide multiply not five cycles");
    property p_mul_half;
        (pipe_req_in.mul_start && !pipe_req_in.mul_wide && !mul_busy_out)
            |=> mul_busy_out [*3] ##1 (mul_done_out && (mdl_r == $past(prod_half)));
    endproperty
    a_mul_half: assert property (p_mul_half) else $error("half multiply wrong");
    property p_dstep_early;
        (pipe_req_in.dstep_we && (pipe_req_in.ps_op == cpsreg_pkg::PS_OP_NONE) && !reti_take)
            |=> ps_out[10:9] == $past(pipe_req_in.dstep_val);
    endproperty
    a_dstep_early: assert property (p_dstep_early) else $error("divide flags not updated");
    property p_ilm_store;
        ((pipe_req_in.ps_op == cpsreg_pkg::PS_OP_SET_ILM) && !reti_take && !ent_finish)
            |=> ps_out[20:16] == $past(pipe_req_in.ps_val[4:0]);
    endproperty
    a_ilm_store: assert property (p_ilm_store) else $error("level mask store lost");
    property p_reti_restore;
        (reti_take && !ent_accept) |=> (ps_out == $past(saved_ps_r)) && (nzvc_out == $past(saved_nzvc_r));
    endproperty
    a_reti_restore: assert property (p_reti_restore) else $error("status not restored");
    property p_sp_alias;
        sp_out == (ps_out[5] ? usp_r : ssp_r);
    endproperty
    a_sp_alias: assert property (p_sp_alias) else $error("stack alias wrong");
    property p_nested_level;
        ent_accept |=> ##5 (entry_done_out == 1'b0) ##1 (ps_out[20:16] == $past(ent_level_r));
    endproperty
    a_nested_level: assert property (p_nested_level) else $error("level not raised");
endmodule // cpsreg_top

// ### dv/cpsreg_pipe_model.sv
`timescale 1ns/10ps
// stands in for the execution pipeline: one request per call, pulses last one cycle except exc_req/exc_level, held until entry is seen or 10 more cycles pass
module cpsreg_pipe_model (
    input wire logic sys_clk_in,
    input wire logic entry_busy_in,
    output cpsreg_pkg::cpsreg_pipe_req_t pipe_req_out
);
    cpsreg_pkg::cpsreg_pipe_req_t req_r = '0;
    assign pipe_req_out = req_r;

    task automatic send(input cpsreg_pkg::cpsreg_pipe_req_t r);
        cpsreg_pkg::cpsreg_pipe_req_t h;
        bit seen;
        h = '0;
        h.exc_req = r.exc_req;
        h.exc_level = r.exc_level;
        seen = 1'b0;
        @(posedge sys_clk_in);
        req_r <= r;
        @(posedge sys_clk_in);
        if (r.exc_req) begin
            // exception request is a level: keep it up until entry is seen, bounded
            req_r <= h;
            for (int i = 0; i < 10 && !seen; i++) begin
                @(posedge sys_clk_in);
                seen = (entry_busy_in === 1'b1);
            end
        end
        req_r <= '0;
    endtask
endmodule // cpsreg_pipe_model

// ### dv/cpsreg_top_test.sv
`timescale 1ns/10ps
module cpsreg_top_test;
    logic sys_clk_in;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out, ps_out, sp_out, d;
    logic [3:0] nzvc_out;
    logic entry_busy_out, entry_done_out, mul_busy_out, mul_done_out;
    cpsreg_pkg::cpsreg_pipe_req_t pipe_req, q;
    int errors = 0;
    int tests_run = 0;
    int ent_n = 0;
    int mul_n = 0;
    int n0;
    cpsreg_pkg::cpsreg_ps_op_t ops [3] = '{cpsreg_pkg::PS_OP_OR_CCR,
        cpsreg_pkg::PS_OP_SET_ILM, cpsreg_pkg::PS_OP_MOVE};
    logic [31:0] op_val [3] = '{32'h00000012, 32'h0000001f, 32'hffffffff};
    logic [31:0] op_exp [3] = '{32'h00000010, 32'h001f0010, 32'h001f0730};

    cpsreg_top DUT (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .pipe_req_in(pipe_req),
        .ps_out(ps_out),
        .nzvc_out(nzvc_out),
        .sp_out(sp_out),
        .entry_busy_out(entry_busy_out),
        .entry_done_out(entry_done_out),
        .mul_busy_out(mul_busy_out),
        .mul_done_out(mul_done_out)
    );

    cpsreg_pipe_model PIPE (
        .sys_clk_in(sys_clk_in),
        .entry_busy_in(entry_busy_out),
        .pipe_req_out(pipe_req)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // busy cycles are counted at every rising edge so the length of each phase can be compared
    always @(posedge sys_clk_in) begin
        if (entry_busy_out === 1'b1) ent_n <= ent_n + 1;
        if (mul_busy_out === 1'b1) mul_n <= mul_n + 1;
    end

    task automatic results();
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        v = reg_rdata_out;
    endtask

    task automatic pipe(input cpsreg_pkg::cpsreg_pipe_req_t r);
        PIPE.send(r);
        #1;
    endtask

    task automatic wait_done(input bit mul);
        for (int i = 0; i < 20 && (mul ? mul_done_out : entry_done_out) !== 1'b1; i++) begin
            @(posedge sys_clk_in);
        end
        chk(32'((mul ? mul_done_out : entry_done_out) === 1'b1), 32'h00000001);
        @(posedge sys_clk_in);
        #1;
        chk(32'(mul ? mul_done_out : entry_done_out), 32'h00000000);
    endtask

    initial begin
        #20000;
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk(ps_out, cpsreg_pkg::PS_RESET);
        chk(sp_out, cpsreg_pkg::SSP_RESET);
        rd(8'h40, d);
        chk(d & ~cpsreg_pkg::PS_NZVC_MASK, 32'h000f0000);
        @(posedge sys_clk_in);
        #1;
        chk(reg_rdata_out, 32'h00000000);
        for (int i = 0; i < 16; i++) wr(8'(i * 4), 32'ha5000000 | i);
        for (int i = 0; i < 16; i++) begin
            rd(8'(i * 4), d);
            chk(d, 32'ha5000000 | i);
        end
        rd(8'h4c, d);
        chk(d, 32'ha500000f);
        wr(8'h40, 32'h00000020);
        wr(8'h3c, 32'h0000beef);
        chk(sp_out, 32'h0000beef);
        rd(8'h50, d);
        chk(d, 32'h0000beef);
        rd(8'h4c, d);
        chk(d, 32'ha500000f);
        wr(8'h80, 32'hffffffff);
        rd(8'h80, d);
        chk(d, 32'h00000000);
        wr(8'h40, 32'hffffffff);
        chk(ps_out, 32'h001f0730);
        rd(8'h40, d);
        chk(d, cpsreg_pkg::PS_DEF_MASK);
        q = '0;
        q.gpr_we = 1'b1;
        q.gpr_idx = 4'h5;
        q.gpr_wdata = 32'h12345678;
        pipe(q);
        rd(8'h14, d);
        chk(d, 32'h12345678);
        wr(8'h40, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            q = '0;
            q.ps_op = ops[i];
            q.ps_val = op_val[i];
            pipe(q);
            chk(ps_out, op_exp[i]);
            if (i == 0) chk(32'(nzvc_out), 32'h00000002);
        end
        // interrupt taken in the same cycle as a divide step: the step result must survive
        wr(8'h40, 32'h000f0010);
        q = '0;
        q.exc_req = 1'b1;
        q.exc_level = 5'h03;
        q.dstep_we = 1'b1;
        q.dstep_val = 2'b11;
        n0 = ent_n;
        pipe(q);
        wait_done(1'b0);
        chk(32'(ent_n - n0), 32'(cpsreg_pkg::ENTRY_CYC));
        chk(32'(ps_out[20:16]), 32'h00000003);
        chk(32'(ps_out[5]), 32'h00000000);
        chk(32'(ps_out[10:9]), 32'h00000003);
        rd(8'h54, d);
        chk(d, 32'h000f0610);
        q = '0;
        q.reti = 1'b1;
        pipe(q);
        chk(ps_out, 32'h000f0610);
        q = '0;
        q.dstep_we = 1'b1;
        q.dstep_val = 2'b11;
        pipe(q);
        chk(ps_out, 32'h000f0610);
        q = '0;
        q.ps_op = cpsreg_pkg::PS_OP_SET_ILM;
        q.ps_val = 32'h00000003;
        pipe(q);
        chk(ps_out, 32'h00030610);
        q = '0;
        q.exc_req = 1'b1;
        q.exc_level = 5'h03;
        n0 = ent_n;
        pipe(q);
        chk(32'(ent_n - n0), 32'h00000000);
        q.exc_level = 5'h02;
        pipe(q);
        wait_done(1'b0);
        chk(32'(ent_n - n0), 32'(cpsreg_pkg::ENTRY_CYC));
        chk(32'(ps_out[20:16]), 32'h00000002);
        q = '0;
        q.mul_start = 1'b1;
        q.mul_wide = 1'b1;
        q.mul_a = 32'hfffffffd;
        q.mul_b = 32'h00000007;
        n0 = mul_n;
        pipe(q);
        wait_done(1'b1);
        chk(32'(mul_n - n0), 32'(cpsreg_pkg::MUL_WIDE_CYC));
        rd(8'h44, d);
        chk(d, 32'hffffffff);
        rd(8'h48, d);
        chk(d, 32'hffffffeb);
        q.mul_wide = 1'b0;
        q.mul_a = 32'h0000fffe;
        q.mul_b = 32'h00000003;
        n0 = mul_n;
        pipe(q);
        wait_done(1'b1);
        chk(32'(mul_n - n0), 32'(cpsreg_pkg::MUL_HALF_CYC));
        rd(8'h48, d);
        chk(d, 32'hfffffffa);
        rd(8'h44, d);
        chk(d, 32'hffffffff);
        results();
    end
endmodule // cpsreg_top_test
